// file: hdl/fsf_flags.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Double-fault flag with its enable set raises the double-fault interrupt.
// RL2: Single-fault flag with its enable set raises the single-fault interrupt.
// RL3: Both enable bits of the error configuration register read back.
// RL4: Writing 1 to command-complete launches; flag stays low until done or a violation.
// RL5: Bad sequence or command sets access error; it blocks launching.
// RL6: Access error clears only on a written 1.
// RL7: Protected program or erase sets violation; it blocks any command.
// RL8: Protection violation clears only on a written 1.
// RL9: Busy bit reads 1 while the controller executes a command.
// RL10: Status bit 2 reads 0 and ignores writes.
// RL11: Completion status bits show errors from command or reset sequence.
// RL12: Status flags writable, busy and completion read-only, rest zero.
// RL13: Double fault or read collision with a command sets double flag.
// RL14: Unignored single fault with no double fault or force, or a collision, sets the single-fault flag.
// RL15: Both fault flags clear only on a written 1.
// RL16: Real faults set one flag only; collisions set both flags.
// RL17: Fault flags are stored one cycle after the faulting read.
// RL18: Ignore-single-fault stops single faults setting flag or interrupt.
// RL19: Force-double-fault makes every read set the double-fault flag.
// RL20: Writing 0 to command-complete does nothing; error bits reset to 0.
module fsf_flags (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsf_pkg::ADDR_W-1:0] paddr,
  input wire logic [fsf_pkg::DATA_W-1:0] pwdata,
  output logic [fsf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mc_cmd_done,
  input wire logic mc_seq_violation,
  input wire logic mc_prot_violation,
  input wire logic mc_busy,
  input wire logic [1:0] mc_completion_status,
  input wire logic arr_read,
  input wire logic arr_single_fault,
  input wire logic arr_double_fault,
  input wire logic arr_collision,
  output logic cmd_launch,
  output logic cmd_seq_allowed,
  output logic double_fault_irq,
  output logic single_fault_irq
);
  import fsf_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] err_cfg;
    logic ignore_single_fault;
    logic force_double_fault;
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic double_fault_flag;
    logic single_fault_flag;
    logic stg_read;
    logic stg_sf;
    logic stg_df;
    logic stg_coll;
    logic launch;
    logic seq_allowed;
    logic df_irq;
    logic sf_irq;
  } fsf_state_t;

  fsf_state_t s_reg;
  fsf_state_t s_next;
  logic wr_en;
  logic access;
  logic [5:0] idx;
  logic hit;
  logic [DATA_W-1:0] rd_word;
  logic [7:0] status_byte;
  logic set_df;
  logic set_sf;
  logic do_launch;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode and read data.

  assign idx = paddr[ADDR_W-1:2];
  assign access = psel && penable;
  assign wr_en = access && pwrite && s_reg.pready;
  assign hit = (idx == IDX_CONFIG) || (idx == IDX_ERR_CFG) ||
               (idx == IDX_STATUS) || (idx == IDX_ERR_STATUS);

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_CMD_COMPLETE] = s_reg.cmd_complete_flag; // [RL12]
    status_byte[ST_ACCESS_ERR] = s_reg.access_error_flag;
    status_byte[ST_PROT_VIOL] = s_reg.protection_violation_flag;
    status_byte[ST_BUSY] = mc_busy; // [RL9]
    status_byte[ST_RESERVED] = 1'b0; // [RL10]
    status_byte[ST_COMPL_HI:ST_COMPL_LO] = mc_completion_status; // [RL11]
  end

  always_comb begin
    rd_word = RDATA_ZERO;
    case (idx)
      IDX_CONFIG: begin
        rd_word[CFG_IGNORE_SF] = s_reg.ignore_single_fault;
        rd_word[CFG_FORCE_DF] = s_reg.force_double_fault;
      end
      IDX_ERR_CFG: begin
        rd_word[ECFG_DF_IE:ECFG_SF_IE] = s_reg.err_cfg; // [RL3]
      end
      IDX_STATUS: begin
        rd_word[ST_CMD_COMPLETE:ST_COMPL_LO] = status_byte;
      end
      IDX_ERR_STATUS: begin
        rd_word[EST_DF] = s_reg.double_fault_flag;
        rd_word[EST_SF] = s_reg.single_fault_flag;
      end
      default: begin
        rd_word = RDATA_ZERO;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault event decode from the staged array read.

  always_comb begin
    set_df = 1'b0;
    set_sf = 1'b0;
    if (s_reg.stg_read) begin
      if (s_reg.stg_coll) begin
        set_df = 1'b1; // [RL13] [RL16]
        set_sf = 1'b1; // [RL14]
      end else if (s_reg.force_double_fault || s_reg.stg_df) begin
        set_df = 1'b1; // [RL19] [RL16]
      end else if (s_reg.stg_sf && !s_reg.ignore_single_fault) begin
        set_sf = 1'b1; // [RL14] [RL18]
      end
    end
  end

  assign do_launch = wr_en && (idx == IDX_STATUS) &&
                     pwdata[ST_CMD_COMPLETE] && s_reg.cmd_complete_flag &&
                     !s_reg.access_error_flag &&
                     !s_reg.protection_violation_flag; // [RL5] [RL7]

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_next = s_reg;
    s_next.pready = access && !s_reg.pready;
    s_next.pslverr = access && !s_reg.pready && !hit;
    s_next.prdata = (access && !s_reg.pready) ? rd_word : RDATA_ZERO;
    // Array read is staged one cycle before the flags are stored.
    s_next.stg_read = arr_read; // [RL17]
    s_next.stg_sf = arr_single_fault;
    s_next.stg_df = arr_double_fault;
    s_next.stg_coll = arr_collision;
    s_next.launch = do_launch; // [RL4]
    if (wr_en && (idx == IDX_CONFIG)) begin
      s_next.ignore_single_fault = pwdata[CFG_IGNORE_SF];
      s_next.force_double_fault = pwdata[CFG_FORCE_DF]; // [RL19]
    end
    if (wr_en && (idx == IDX_ERR_CFG)) begin
      s_next.err_cfg = pwdata[ECFG_DF_IE:ECFG_SF_IE]; // [RL3]
    end
    // Clears by written ones first, so that a same-cycle set wins.
    if (wr_en && (idx == IDX_STATUS)) begin
      if (pwdata[ST_ACCESS_ERR]) begin
        s_next.access_error_flag = 1'b0; // [RL6]
      end
      if (pwdata[ST_PROT_VIOL]) begin
        s_next.protection_violation_flag = 1'b0; // [RL8]
      end
    end
    if (wr_en && (idx == IDX_ERR_STATUS)) begin
      if (pwdata[EST_DF]) begin
        s_next.double_fault_flag = 1'b0; // [RL15]
      end
      if (pwdata[EST_SF]) begin
        s_next.single_fault_flag = 1'b0; // [RL15]
      end
    end
    if (do_launch) begin
      s_next.cmd_complete_flag = 1'b0; // [RL4] [RL20]
    end
    if (mc_seq_violation) begin
      s_next.access_error_flag = 1'b1; // [RL5]
    end
    if (mc_prot_violation) begin
      s_next.protection_violation_flag = 1'b1; // [RL7]
    end
    if (!s_reg.cmd_complete_flag &&
        (mc_cmd_done || mc_seq_violation || mc_prot_violation)) begin
      s_next.cmd_complete_flag = 1'b1; // [RL4]
    end
    if (set_df) begin
      s_next.double_fault_flag = 1'b1; // [RL13]
    end
    if (set_sf) begin
      s_next.single_fault_flag = 1'b1; // [RL14]
    end
    s_next.seq_allowed = !s_next.access_error_flag &&
                         !s_next.protection_violation_flag; // [RL7]
    s_next.df_irq = s_next.double_fault_flag &&
                    s_next.err_cfg[ECFG_DF_IE]; // [RL1]
    s_next.sf_irq = s_next.single_fault_flag &&
                    s_next.err_cfg[ECFG_SF_IE]; // [RL2]
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0; // [RL20]
      s_reg.cmd_complete_flag <= RST_CMD_COMPLETE;
      s_reg.err_cfg <= RST_ERR_CFG;
      s_reg.seq_allowed <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cmd_launch = s_reg.launch;
  assign cmd_seq_allowed = s_reg.seq_allowed;
  assign double_fault_irq = s_reg.df_irq;
  assign single_fault_irq = s_reg.sf_irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence launch_wr;
    ce && do_launch;
  endsequence

  sequence read_fault_df;
    ce && arr_read && arr_double_fault && !arr_collision;
  endsequence

  sequence status_read_req;
    ce && access && !pready && idx == IDX_STATUS;
  endsequence

  a_irq_double: assert property ( // [RL1]
    ce |=> double_fault_irq ==
      ($past(s_next.double_fault_flag) && $past(s_next.err_cfg[ECFG_DF_IE])))
    else $error("double fault interrupt mismatch");

  a_irq_single: assert property ( // [RL2]
    ce && s_next.single_fault_flag && !s_next.err_cfg[ECFG_SF_IE]
      |=> !single_fault_irq)
    else $error("single fault interrupt not gated");

  a_cfg_readback: assert property ( // [RL3]
    ce && wr_en && idx == IDX_ERR_CFG |=> s_reg.err_cfg == $past(pwdata[1:0]))
    else $error("error config write not stored");

  a_launch_clear: assert property ( // [RL4]
    launch_wr |=> cmd_launch && !s_reg.cmd_complete_flag)
    else $error("launch did not clear command complete");

  a_access_error_flag_block: assert property ( // [RL5]
    ce && s_reg.access_error_flag && wr_en && idx == IDX_STATUS &&
      pwdata[ST_CMD_COMPLETE] |=> !cmd_launch)
    else $error("launch while access error set");

  a_cc_return: assert property ( // [RL4]
    ce && !s_reg.cmd_complete_flag && mc_cmd_done
      |=> s_reg.cmd_complete_flag)
    else $error("command complete not returned");

  a_cc_hold: assert property ( // [RL4]
    ce && !s_reg.cmd_complete_flag && !mc_cmd_done &&
      !mc_seq_violation && !mc_prot_violation
      |=> !s_reg.cmd_complete_flag)
    else $error("command complete rose while running");

  a_cc_write0: assert property ( // [RL20]
    ce && wr_en && idx == IDX_STATUS && !pwdata[ST_CMD_COMPLETE] &&
      !mc_cmd_done && !mc_seq_violation && !mc_prot_violation
      |=> $stable(s_reg.cmd_complete_flag))
    else $error("writing zero changed command complete");

  a_access_error_flag_set: assert property ( // [RL5]
    ce && mc_seq_violation
      |=> s_reg.access_error_flag && !cmd_seq_allowed)
    else $error("access error not latched");

  a_access_error_flag_hold: assert property ( // [RL6]
    ce && s_reg.access_error_flag &&
      !(wr_en && idx == IDX_STATUS && pwdata[ST_ACCESS_ERR])
      |=> s_reg.access_error_flag)
    else $error("access error cleared without written one");

  a_pviol_set: assert property ( // [RL7]
    ce && mc_prot_violation |=> s_reg.protection_violation_flag &&
      !cmd_seq_allowed)
    else $error("protection violation not latched");

  a_pviol_hold: assert property ( // [RL8]
    ce && s_reg.protection_violation_flag &&
      !(wr_en && idx == IDX_STATUS && pwdata[ST_PROT_VIOL])
      |=> s_reg.protection_violation_flag)
    else $error("protection violation cleared without written one");

  a_status_read: assert property ( // [RL12] [RL10] [RL9]
    status_read_req
      |=> pready && prdata[ST_RESERVED] == 1'b0 &&
          prdata[ST_BUSY] == $past(mc_busy) &&
          prdata[DATA_W-1:ST_CMD_COMPLETE+1] == '0)
    else $error("status read data wrong");

  a_compl_live: assert property ( // [RL11]
    status_read_req
      |=> prdata[ST_COMPL_HI:ST_COMPL_LO] == $past(mc_completion_status))
    else $error("completion status read wrong");

  a_df_delay: assert property ( // [RL17]
    read_fault_df ##1 ce |=> s_reg.double_fault_flag && !$past(set_sf))
    else $error("double fault not stored after one cycle");

  a_collide_both: assert property ( // [RL16]
    ce && s_reg.stg_read && s_reg.stg_coll
      |=> s_reg.double_fault_flag && s_reg.single_fault_flag)
    else $error("collision did not set both flags");

  a_ignore_sf: assert property ( // [RL18]
    ce && s_reg.stg_read && s_reg.stg_sf && !s_reg.stg_coll &&
      s_reg.ignore_single_fault && !s_reg.single_fault_flag
      |=> !s_reg.single_fault_flag && !single_fault_irq)
    else $error("ignored single fault reported");

  a_force_df: assert property ( // [RL19]
    ce && s_reg.stg_read && s_reg.force_double_fault
      |=> s_reg.double_fault_flag)
    else $error("forced double fault not set");

  a_flag_hold: assert property ( // [RL15]
    ce && s_reg.double_fault_flag &&
      !(wr_en && idx == IDX_ERR_STATUS && pwdata[EST_DF])
      |=> s_reg.double_fault_flag)
    else $error("double fault flag cleared without written one");

  a_sf_hold: assert property ( // [RL15]
    ce && s_reg.single_fault_flag &&
      !(wr_en && idx == IDX_ERR_STATUS && pwdata[EST_SF])
      |=> s_reg.single_fault_flag)
    else $error("single fault flag cleared without written one");

  a_sf_set: assert property ( // [RL14]
    ce && s_reg.stg_read && s_reg.stg_sf && !s_reg.stg_df &&
      !s_reg.force_double_fault && !s_reg.ignore_single_fault
      |=> s_reg.single_fault_flag)
    else $error("single fault not stored");

  a_one_flag: assert property ( // [RL16]
    ce && s_reg.stg_read && !s_reg.stg_coll &&
      !s_reg.double_fault_flag && !s_reg.single_fault_flag
      |=> !(s_reg.double_fault_flag && s_reg.single_fault_flag))
    else $error("real fault set both flags");

  a_apb_answer: assert property (
    ce && access && !pready |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
endmodule

// file: hdl/fsf_pkg.sv
package fsf_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CONFIG = 6'h04;
  localparam logic [5:0] IDX_ERR_CFG = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_ERR_STATUS = 6'h07;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Configuration register fields.
  localparam int CFG_IGNORE_SF = 4;
  localparam int CFG_FORCE_DF = 1;
  // Error configuration register fields.
  localparam int ECFG_DF_IE = 1;
  localparam int ECFG_SF_IE = 0;
  // Status register fields.
  localparam int ST_CMD_COMPLETE = 7;
  localparam int ST_ACCESS_ERR = 5;
  localparam int ST_PROT_VIOL = 4;
  localparam int ST_BUSY = 3;
  localparam int ST_RESERVED = 2;
  localparam int ST_COMPL_HI = 1;
  localparam int ST_COMPL_LO = 0;
  // Error status register fields.
  localparam int EST_DF = 1;
  localparam int EST_SF = 0;
  // Reset values.
  localparam logic RST_CMD_COMPLETE = 1'b1;
  localparam logic [1:0] RST_ERR_CFG = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
endpackage

// file: testbench/fsf_ctl_model.sv
`timescale 1ns/1ps
// Memory controller model: runs each launched command for RUN cycles.
module fsf_ctl_model #(parameter int RUN = 12) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_launch,
  input wire logic [1:0] mode,
  output logic mc_cmd_done,
  output logic mc_seq_violation,
  output logic mc_prot_violation,
  output logic mc_busy,
  output logic [1:0] mc_completion_status
);
  int cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      mc_busy <= 1'b0;
      mc_cmd_done <= 1'b0;
      mc_seq_violation <= 1'b0;
      mc_prot_violation <= 1'b0;
      mc_completion_status <= 2'h0;
    end else begin
      mc_cmd_done <= 1'b0;
      mc_seq_violation <= 1'b0;
      mc_prot_violation <= 1'b0;
      if (cmd_launch) begin
        mc_busy <= 1'b1;
        mc_completion_status <= 2'h0;
        cnt <= RUN;
      end else if (mc_busy && cnt == 1) begin
        mc_busy <= 1'b0;
        mc_cmd_done <= (mode == 2'h0);
        mc_seq_violation <= (mode == 2'h1);
        mc_prot_violation <= (mode == 2'h2);
        mc_completion_status <= mode;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// file: testbench/flash_status_error_flags_tb_top.sv
`timescale 1ns/1ps
module flash_status_error_flags_tb_top;
  logic clk = 1'b0;
  logic rstn, psel, penable, pwrite, pready, pslverr, e, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic done, seqv, protv, busy, launch, allowed, dirq, sirq;
  logic [1:0] compl, mode;
  logic ar, asf, adf, acol;
  int n_mismatch, samples_checked, cyc, launches, l0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x;} fsf_row_t;
  fsf_row_t rows [6] = '{'{8'h14, 32'h3, 32'h3}, '{8'h14, 32'hfc, 32'h0},
    '{8'h10, 32'hff, 32'h12}, '{8'h10, 32'h0, 32'h0},
    '{8'h18, 32'h4f, 32'h80}, '{8'h1c, 32'hff, 32'h0}};
  typedef struct {logic [31:0] cfg; logic [1:0] en; logic s, d, c;
    logic [1:0] x;} fsf_ecc_t;
  fsf_ecc_t ecc [8] = '{
    '{32'h00, 2'h3, 1'b1, 1'b0, 1'b0, 2'h1},
    '{32'h00, 2'h3, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h00, 2'h3, 1'b0, 1'b0, 1'b1, 2'h3},
    '{32'h00, 2'h3, 1'b1, 1'b1, 1'b0, 2'h2},
    '{32'h00, 2'h0, 1'b0, 1'b0, 1'b1, 2'h3},
    '{32'h10, 2'h3, 1'b1, 1'b0, 1'b0, 2'h0},
    '{32'h10, 2'h3, 1'b0, 1'b0, 1'b1, 2'h3},
    '{32'h02, 2'h2, 1'b0, 1'b0, 1'b0, 2'h2}};
  logic [31:0] stat [3] = '{32'h80, 32'ha1, 32'h92};
  fsf_flags u_dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mc_cmd_done(done), .mc_seq_violation(seqv),
    .mc_prot_violation(protv), .mc_busy(busy),
    .mc_completion_status(compl), .arr_read(ar), .arr_single_fault(asf),
    .arr_double_fault(adf), .arr_collision(acol), .cmd_launch(launch),
    .cmd_seq_allowed(allowed), .double_fault_irq(dirq),
    .single_fault_irq(sirq));
  fsf_ctl_model u_ctl (.clk(clk), .rstn(rstn), .cmd_launch(launch),
    .mode(mode), .mc_cmd_done(done), .mc_seq_violation(seqv),
    .mc_prot_violation(protv), .mc_busy(busy),
    .mc_completion_status(compl));
  //////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (launch === 1'b1) launches++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk_word(r, x);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, ar, asf, adf, acol} = '0;
    {paddr, pwdata, mode} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h18, 32'h80);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h14, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk_bit(e, 1'b1);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].x);
    end
    for (int m = 0; m < 3; m++) begin
      mode <= m[1:0];
      l0 = launches;
      apb(1'b1, 8'h18, 32'h80);
      rd_chk(8'h18, 32'h08);
      chk_word(launches - l0, 32'h1);
      for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
      rd_chk(8'h18, stat[m]);
      if (m != 0) begin
        chk_bit(allowed, 1'b0);
        apb(1'b1, 8'h18, 32'h80);
        apb(1'b1, 8'h18, 32'h0);
        rd_chk(8'h18, stat[m]);
        apb(1'b1, 8'h18, stat[m] & 32'h30);
        rd_chk(8'h18, stat[m] & 32'h83);
        chk_word(launches - l0, 32'h1);
        chk_bit(allowed, 1'b1);
      end
    end
    foreach (ecc[i]) begin
      apb(1'b1, 8'h10, ecc[i].cfg);
      apb(1'b1, 8'h14, {30'h0, ecc[i].en});
      @(posedge clk);
      {ar, asf, adf, acol} <= {1'b1, ecc[i].s, ecc[i].d, ecc[i].c};
      @(posedge clk);
      {ar, asf, adf, acol} <= 4'h0;
      rd_chk(8'h1c, {30'h0, ecc[i].x});
      chk_bit(dirq, ecc[i].x[1] & ecc[i].en[1]);
      chk_bit(sirq, ecc[i].x[0] & ecc[i].en[0]);
      apb(1'b1, 8'h1c, 32'h0);
      rd_chk(8'h1c, {30'h0, ecc[i].x});
      apb(1'b1, 8'h1c, 32'h3);
      rd_chk(8'h1c, 32'h0);
    end
    // Clock enable low: a read pulse in the frozen cycles is lost.
    @(posedge clk);
    ce <= 1'b0;
    {ar, acol} <= 2'h3;
    @(posedge clk);
    {ar, acol} <= 2'h0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rd_chk(8'h1c, 32'h0);
    // Reset in mid-run clears set flags, enables and configuration.
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h10, 32'h10);
    @(posedge clk);
    {ar, acol} <= 2'h3;
    @(posedge clk);
    {ar, acol} <= 2'h0;
    rd_chk(8'h1c, 32'h3);
    chk_bit(dirq, 1'b1);
    chk_bit(sirq, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_bit(dirq, 1'b0);
    chk_bit(sirq, 1'b0);
    chk_bit(allowed, 1'b1);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h18, 32'h80);
    report_and_stop();
  end
endmodule
